// ---- rtl/sma_ack_filter.sv ----
// receive delivery and auto acknowledgement decision with axi4-lite registers
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module sma_ack_filter
   import sma_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // axi4-lite write address and data
   input wire logic [sma_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [sma_pkg::DATA_W-1:0] s_axi_wdata_in,
   input wire logic [sma_pkg::STRB_W-1:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read
   input wire logic [sma_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [sma_pkg::DATA_W-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // received frame from the parser
   input wire logic rx_valid_in,
   input wire sma_pkg::sma_rx_frame_s rx_frame_in,
   // transmit sequencer
   input wire logic tr_start_in,
   input wire sma_pkg::sma_tx_frame_s tx_frame_in,
   input wire logic tx_done_in,
   input wire logic seq_abort_in,
   // results
   output logic data_ind_out,
   output logic buf_store_out,
   output logic ack_send_out,
   output logic seq_busy_out,
   output logic irq_out
);
   import sma_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [STRB_W-1:0] wstrb_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [DATA_W-1:0] rdata_q;
   logic [CTRL_W-1:0] ctrl_q;
   logic [STAT_W-1:0] status_q;
   logic [STAT_W-1:0] status_d;
   logic [STAT_W-1:0] mask_q;
   logic [15:0] pan_q;
   logic [15:0] short_q;
   logic [63:0] long_q;
   logic [7:0] last_seq_q;
   logic [1:0] last_ver_q;
   sma_seq_e state_q;
   sma_seq_e state_d;
   sma_tx_frame_s sent_q;
   logic expect_q;
   logic data_ind_q;
   logic data_ind_d;
   logic buf_store_q;
   logic buf_store_d;
   logic ack_send_q;
   logic ack_send_d;
   logic seq_busy_q;
   logic irq_q;
   logic filt_match;
   logic filt_ack_ok;
   logic do_write;
   logic [DATA_W-1:0] rd_data;
   logic rd_err;
   logic wr_err;
   logic [STAT_W-1:0] status_clr;
   logic [STAT_W-1:0] status_set;
   logic is_ack;
   logic sniff_any;
   logic plain_sniff;
   logic ack_match;

   function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [STRB_W-1:0] be);
      logic [DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < STRB_W; i++) begin
         if (be[i]) begin
            r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // address filter
   // ----------------------------------------
   sma_addr_filter u_filter (
      .frame_in(rx_frame_in),
      .own_pan_in(pan_q),
      .own_short_in(short_q),
      .own_long_in(long_q),
      .addr_match_out(filt_match),
      .ack_ok_out(filt_ack_ok)
   );

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   // address and data may arrive in either order; the write fires once both are held
   assign do_write = !awready_q && !wready_q && !bvalid_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (awready_q && s_axi_awvalid_in) begin
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr_in;
         end else if (bvalid_q && s_axi_bready_in) begin
            awready_q <= 1'b1;
         end
         if (wready_q && s_axi_wvalid_in) begin
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
         end else if (bvalid_q && s_axi_bready_in) begin
            wready_q <= 1'b1;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_q && s_axi_bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      case (awaddr_q)
         OFF_CTRL, OFF_STATUS, OFF_MASK, OFF_PAN, OFF_SHORT, OFF_LONG_LO, OFF_LONG_HI, OFF_LAST_RX: begin
            wr_err = 1'b0;
         end
         default: begin
            wr_err = 1'b1;
         end
      endcase
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= CTRL_RST; // ack-aware sniff clear: normal operation
         mask_q <= STAT_RST;
         pan_q <= ADDR16_RST;
         short_q <= ADDR16_RST;
         long_q <= ADDR64_RST;
      end else if (do_write) begin
         case (awaddr_q)
            OFF_CTRL: ctrl_q <= CTRL_W'(wmerge(DATA_W'(ctrl_q), wdata_q, wstrb_q));
            OFF_MASK: mask_q <= STAT_W'(wmerge(DATA_W'(mask_q), wdata_q, wstrb_q));
            OFF_PAN: pan_q <= 16'(wmerge(DATA_W'(pan_q), wdata_q, wstrb_q));
            OFF_SHORT: short_q <= 16'(wmerge(DATA_W'(short_q), wdata_q, wstrb_q));
            OFF_LONG_LO: long_q[31:0] <= wmerge(long_q[31:0], wdata_q, wstrb_q);
            OFF_LONG_HI: long_q[63:32] <= wmerge(long_q[63:32], wdata_q, wstrb_q);
            default: begin
            end
         endcase
      end
   end

   // write-one-to-clear, a hardware set in the same cycle wins
   always_comb begin
      status_clr = '0;
      if (do_write && awaddr_q == OFF_STATUS) begin
         status_clr = wdata_q[STAT_W-1:0] & {STAT_W{wstrb_q[0]}};
      end
      status_set = '0;
      status_set[ST_DATA_IND] = data_ind_d;
      status_set[ST_ACK_SENT] = ack_send_d;
      status_set[ST_ACK_MATCH] = ack_match && rx_valid_in;
      status_set[ST_FCS_BAD] = rx_valid_in && !rx_frame_in.fcs_ok;
      status_d = (status_q & ~status_clr) | status_set;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         status_q <= STAT_RST;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q <= |(status_q & mask_q);
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   always_comb begin
      rd_data = '0;
      rd_err = 1'b0;
      case (s_axi_araddr_in)
         OFF_CTRL: rd_data = DATA_W'(ctrl_q);
         OFF_STATUS: rd_data = DATA_W'(status_q);
         OFF_MASK: rd_data = DATA_W'(mask_q);
         OFF_PAN: rd_data = DATA_W'(pan_q);
         OFF_SHORT: rd_data = DATA_W'(short_q);
         OFF_LONG_LO: rd_data = long_q[31:0];
         OFF_LONG_HI: rd_data = long_q[63:32];
         OFF_LAST_RX: rd_data = DATA_W'({state_q, last_ver_q, last_seq_q});
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else if (arready_q && s_axi_arvalid_in) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_data;
         rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_q && s_axi_rready_in) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // transmit-then-receive sequencer
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         SEQ_IDLE: begin
            if (tr_start_in) begin
               state_d = SEQ_TX;
            end
         end
         SEQ_TX: begin
            if (tx_done_in) begin
               state_d = expect_q ? SEQ_ACK_WAIT : SEQ_IDLE;
            end
         end
         SEQ_ACK_WAIT: begin
            if (rx_valid_in && rx_frame_in.ftype == FT_ACK) begin
               state_d = SEQ_IDLE;
            end
         end
         default: state_d = SEQ_IDLE;
      endcase
      if (seq_abort_in) begin
         state_d = SEQ_IDLE;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state_q <= SEQ_IDLE;
         seq_busy_q <= 1'b0;
         expect_q <= 1'b0;
         sent_q <= '0;
      end else begin
         state_q <= state_d;
         seq_busy_q <= (state_d != SEQ_IDLE);
         if (state_q == SEQ_IDLE && tr_start_in) begin
            expect_q <= ctrl_q[CTRL_EXPECT_ACK];
            sent_q <= tx_frame_in;
         end
      end
   end

   // ----------------------------------------
   // delivery and acknowledgement decision
   // ----------------------------------------
   always_comb begin
      is_ack = (rx_frame_in.ftype == FT_ACK);
      sniff_any = ctrl_q[CTRL_SNIFF] || ctrl_q[CTRL_ACK_AWARE];
      // ack-aware enable overrides plain sniff
      plain_sniff = ctrl_q[CTRL_SNIFF] && !ctrl_q[CTRL_ACK_AWARE];
      ack_match = (state_q == SEQ_ACK_WAIT) && is_ack && rx_frame_in.fcs_ok &&
                  rx_frame_in.seq == sent_q.seq && rx_frame_in.version == sent_q.version;
      data_ind_d = 1'b0;
      if (rx_valid_in) begin
         if (!rx_frame_in.fcs_ok) begin
            data_ind_d = ctrl_q[CTRL_FCS_IND];
         end else if (sniff_any) begin
            data_ind_d = 1'b1;
         end else if (is_ack) begin
            data_ind_d = ack_match;
         end else begin
            data_ind_d = filt_match;
         end
      end
      // ack frames reach the buffer only in ack-aware sniff
      buf_store_d = data_ind_d && (!is_ack || ctrl_q[CTRL_ACK_AWARE]);
      // filter already refuses bad fcs; plain sniff stays silent
      ack_send_d = rx_valid_in && rx_frame_in.fcs_ok && filt_ack_ok && !plain_sniff;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         data_ind_q <= 1'b0;
         buf_store_q <= 1'b0;
         ack_send_q <= 1'b0;
         last_seq_q <= '0;
         last_ver_q <= '0;
      end else begin
         data_ind_q <= data_ind_d;
         buf_store_q <= buf_store_d;
         ack_send_q <= ack_send_d;
         if (rx_valid_in) begin
            last_seq_q <= rx_frame_in.seq;
            last_ver_q <= rx_frame_in.version;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out = wready_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rresp_out = rresp_q;
   assign s_axi_rdata_out = rdata_q;
   assign data_ind_out = data_ind_q;
   assign buf_store_out = buf_store_q;
   assign ack_send_out = ack_send_q;
   assign seq_busy_out = seq_busy_q;
   assign irq_out = irq_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_tr_go;
      state_q == SEQ_TX && tx_done_in && expect_q && !seq_abort_in;
   endsequence
   sequence s_waiting;
      state_q == SEQ_ACK_WAIT && seq_busy_q;
   endsequence

   property p_sniff_ind;
      rx_valid_in && rx_frame_in.fcs_ok && (ctrl_q[CTRL_SNIFF] || ctrl_q[CTRL_ACK_AWARE]) |=> data_ind_q;
   endproperty
   a_sniff_ind: assert property (p_sniff_ind) else $error("sniff frame not indicated");

   property p_plain_noack;
      rx_valid_in && ctrl_q[CTRL_SNIFF] && !ctrl_q[CTRL_ACK_AWARE] |=> !ack_send_q;
   endproperty
   a_plain_noack: assert property (p_plain_noack) else $error("ack in plain sniff");

   property p_aware_ack;
      rx_valid_in && ctrl_q[CTRL_ACK_AWARE] && filt_ack_ok |=> ack_send_q && data_ind_q;
   endproperty
   a_aware_ack: assert property (p_aware_ack) else $error("ack-aware sniff lost ack");

   property p_fcs_ind;
      rx_valid_in && !rx_frame_in.fcs_ok |=> data_ind_q == $past(ctrl_q[CTRL_FCS_IND]);
   endproperty
   a_fcs_ind: assert property (p_fcs_ind) else $error("fcs fail indication wrong");

   property p_fcs_noack;
      rx_valid_in && !rx_frame_in.fcs_ok |=> !ack_send_q;
   endproperty
   a_fcs_noack: assert property (p_fcs_noack) else $error("ack on bad fcs");

   property p_short_bcast;
      rx_valid_in && rx_frame_in.dst_mode == AM_SHORT &&
      (rx_frame_in.dst_pan == BCAST || rx_frame_in.dst_short == BCAST) |=> !ack_send_q;
   endproperty
   a_short_bcast: assert property (p_short_bcast) else $error("ack on short broadcast");

   property p_long_bcast;
      rx_valid_in && rx_frame_in.fcs_ok && !(ctrl_q[CTRL_SNIFF] && !ctrl_q[CTRL_ACK_AWARE]) &&
      rx_frame_in.dst_mode == AM_LONG && rx_frame_in.dst_pan == BCAST && rx_frame_in.dst_long == long_q &&
      (rx_frame_in.ftype == FT_DATA || rx_frame_in.ftype == FT_CMD) && rx_frame_in.ack_req |=> ack_send_q;
   endproperty
   a_long_bcast: assert property (p_long_bcast) else $error("long address ack missing");

   property p_tr_ack;
      s_tr_go |=> s_waiting;
   endproperty
   a_tr_ack: assert property (p_tr_ack) else $error("no ack wait after transmit");

   property p_ack_nostore;
      rx_valid_in && rx_frame_in.ftype == FT_ACK && !ctrl_q[CTRL_ACK_AWARE] |=> !buf_store_q;
   endproperty
   a_ack_nostore: assert property (p_ack_nostore) else $error("ack frame stored");

   property p_ack_match;
      s_waiting ##0 rx_valid_in && rx_frame_in.ftype == FT_ACK && rx_frame_in.fcs_ok &&
      !ctrl_q[CTRL_SNIFF] && !ctrl_q[CTRL_ACK_AWARE] |=>
      data_ind_q == ($past(rx_frame_in.seq) == sent_q.seq && $past(rx_frame_in.version) == sent_q.version);
   endproperty
   a_ack_match: assert property (p_ack_match) else $error("ack match indication wrong");

   property p_aware_store;
      rx_valid_in && ctrl_q[CTRL_ACK_AWARE] && rx_frame_in.fcs_ok && rx_frame_in.ftype == FT_ACK |=> buf_store_q;
   endproperty
   a_aware_store: assert property (p_aware_store) else $error("ack frame not stored");

endmodule
`default_nettype wire

// ---- rtl/sma_pkg.sv ----
// constants, types and register map of the sniff mode ack filter
package sma_pkg;

   // ----------------------------------------
   // bus geometry
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int BYTE_W = 8;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PAN = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_SHORT = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_LONG_LO = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_LONG_HI = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_LAST_RX = 8'h1c;

   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int CTRL_W = 4;
   localparam int CTRL_SNIFF = 0;
   localparam int CTRL_ACK_AWARE = 1;
   localparam int CTRL_FCS_IND = 2;
   localparam int CTRL_EXPECT_ACK = 3;
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam int STAT_W = 4;
   localparam int ST_DATA_IND = 0;
   localparam int ST_ACK_SENT = 1;
   localparam int ST_ACK_MATCH = 2;
   localparam int ST_FCS_BAD = 3;
   localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
   localparam logic [15:0] ADDR16_RST = 16'h0000;
   localparam logic [63:0] ADDR64_RST = 64'h0000_0000_0000_0000;
   localparam logic [15:0] BCAST = 16'hffff;

   // ----------------------------------------
   // frame codes and bus answers
   // ----------------------------------------
   localparam logic [2:0] FT_DATA = 3'h1;
   localparam logic [2:0] FT_ACK = 3'h2;
   localparam logic [2:0] FT_CMD = 3'h3;
   localparam logic [1:0] AM_SHORT = 2'h2;
   localparam logic [1:0] AM_LONG = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic fcs_ok;
      logic [2:0] ftype;
      logic ack_req;
      logic [1:0] version;
      logic [7:0] seq;
      logic [1:0] dst_mode;
      logic [15:0] dst_pan;
      logic [15:0] dst_short;
      logic [63:0] dst_long;
   } sma_rx_frame_s;

   typedef struct packed {
      logic [1:0] version;
      logic [7:0] seq;
   } sma_tx_frame_s;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_TX, SEQ_ACK_WAIT} sma_seq_e;

endpackage

// ---- rtl/sma_addr_filter.sv ----
// destination address filter and acknowledgement decision
`timescale 1ns/1ps
`default_nettype none
module sma_addr_filter
   import sma_pkg::*;
(
   // received frame
   input wire sma_pkg::sma_rx_frame_s frame_in,
   // own identity
   input wire logic [15:0] own_pan_in,
   input wire logic [15:0] own_short_in,
   input wire logic [63:0] own_long_in,
   // decisions
   output logic addr_match_out,
   output logic ack_ok_out
);
   import sma_pkg::*;

   logic pan_bc;
   logic dst_bc;
   logic pan_hit;
   logic acks_type;

   always_comb begin
      pan_bc = (frame_in.dst_pan == BCAST);
      dst_bc = (frame_in.dst_short == BCAST);
      pan_hit = (frame_in.dst_pan == own_pan_in) || pan_bc;
      acks_type = (frame_in.ftype == FT_DATA) || (frame_in.ftype == FT_CMD);
      addr_match_out = 1'b0;
      ack_ok_out = 1'b0;
      case (frame_in.dst_mode)
         AM_SHORT: begin
            addr_match_out = pan_hit && (dst_bc || frame_in.dst_short == own_short_in);
            // any broadcast field in short mode suppresses the ack
            ack_ok_out = !pan_bc && !dst_bc && frame_in.dst_pan == own_pan_in &&
                         frame_in.dst_short == own_short_in;
         end
         AM_LONG: begin
            // unique extended address is acked even on broadcast pan
            addr_match_out = pan_hit && (frame_in.dst_long == own_long_in);
            ack_ok_out = addr_match_out;
         end
         default: begin
            addr_match_out = 1'b0;
            ack_ok_out = 1'b0;
         end
      endcase
      // only data and command frames asking for it are acked
      ack_ok_out = ack_ok_out && acks_type && frame_in.ack_req && frame_in.fcs_ok;
   end
endmodule
`default_nettype wire

// ---- tb/sma_air_node.sv ----
// far-side node model: hands over received frames and ends transmissions
`timescale 1ns/1ps
`default_nettype none
module sma_air_node
   import sma_pkg::*;
#(parameter int TX_DLY = 3)
(
   // clock
   input wire logic clk_in,
   // frame request from the bench and transmit status from the block
   input wire logic send_in,
   input wire sma_pkg::sma_rx_frame_s frame_in,
   input wire logic busy_in,
   // toward the block
   output logic rx_valid_out,
   output sma_pkg::sma_rx_frame_s frame_out,
   output logic tx_done_out
);
   int cnt;
   initial begin
      cnt = 0;
      rx_valid_out = 1'b0;
      frame_out = '0;
      tx_done_out = 1'b0;
   end
   always @(posedge clk_in) begin
      rx_valid_out <= send_in;
      // outside a frame the data is not held, so stale fields cannot pass for good ones
      frame_out <= send_in ? frame_in : ~frame_out;
      cnt <= busy_in ? cnt + 1 : 0;
      tx_done_out <= busy_in && (cnt == TX_DLY);
   end
endmodule
`default_nettype wire

// ---- tb/test_sniff_mode_ack_filter.sv ----
// self-checking bench for the sniff mode ack filter
`timescale 1ns/1ps
`default_nettype none
module test_sniff_mode_ack_filter;
   import sma_pkg::*;
   localparam logic [15:0] OWNP = 16'h1234;
   localparam logic [15:0] OWNS = 16'h5678;
   localparam logic [63:0] LNG = 64'h0123_4567_89ab_cdef;
   localparam logic [9:0] V = 10'h15a;
   logic sys_clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, send = 0, trs = 0;
   logic [7:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, c;
   wire logic awr, wr, bv, arr, rv, rxv, txd, ind, sto, ack, busy, irq;
   wire logic [1:0] br, rresp;
   wire logic [31:0] rdata;
   wire sma_rx_frame_s rxf;
   sma_rx_frame_s f = '0;
   sma_tx_frame_s txf = '0;
   int err_count = 0, total_checks = 0;
   always #20 sys_clk = ~sys_clk;
   sma_ack_filter i_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .rx_valid_in(rxv),
      .rx_frame_in(rxf), .tr_start_in(trs), .tx_frame_in(txf), .tx_done_in(txd), .seq_abort_in(1'b0),
      .data_ind_out(ind), .buf_store_out(sto), .ack_send_out(ack), .seq_busy_out(busy), .irq_out(irq));
   sma_air_node i_air (.clk_in(sys_clk), .send_in(send), .frame_in(f), .busy_in(busy), .rx_valid_out(rxv),
      .frame_out(rxf), .tx_done_out(txd));
   task automatic report_and_stop;
      $display("mismatches %0d of %0d checks", err_count, total_checks);
      if (err_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   // every wait is bounded; a hang ends the run as a failure
   task automatic tmo(input int n);
      if (n >= 50) begin
         chk("wait bound", 0, 1);
         report_and_stop();
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      do begin
         @(posedge sys_clk);
         n++;
         if (awr) awv <= 0;
         if (wr) wv <= 0;
      end while (bv !== 1'b1 && n < 50);
      tmo(n);
      chk("write response", er, br);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      ara <= a;
      arv <= 1;
      rry <= 1;
      do begin
         @(posedge sys_clk);
         n++;
         if (arr) arv <= 0;
      end while (rv !== 1'b1 && n < 50);
      tmo(n);
      chk("read data", e, rdata);
      chk("read response", er, rresp);
   endtask
   function automatic sma_rx_frame_s mk(input logic ok, input logic [2:0] t, input logic aq, input logic [1:0] m,
      input logic [15:0] p, input logic [15:0] s, input logic [63:0] l, input logic [9:0] vs);
      mk = '{fcs_ok:ok, ftype:t, ack_req:aq, version:vs[9:8], seq:vs[7:0], dst_mode:m, dst_pan:p,
         dst_short:s, dst_long:l};
   endfunction
   // e is {indication, store, ack}, seen the cycle after the block takes the frame
   task automatic rx(input sma_rx_frame_s fr, input logic [2:0] e);
      f <= fr;
      send <= 1;
      @(posedge sys_clk);
      send <= 0;
      @(posedge sys_clk);
      #1 chk("ind store ack", {29'h0, e}, {29'h0, ind, sto, ack});
   endtask
   task automatic tr(input logic [9:0] avs, input logic eb, input logic [2:0] e);
      int n;
      n = 0;
      txf <= '{version:V[9:8], seq:V[7:0]};
      trs <= 1;
      @(posedge sys_clk);
      trs <= 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (txd !== 1'b1 && n < 50);
      tmo(n);
      @(posedge sys_clk);
      #1 chk("busy after transmit", {31'h0, eb}, {31'h0, busy});
      rx(mk(1, FT_ACK, 0, 2'h0, 16'h0, 16'h0, 64'h0, avs), e);
      chk("busy after ack", 0, {31'h0, busy});
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1;
      @(posedge sys_clk);
      axi_rd(OFF_CTRL, 32'h0, RESP_OKAY);
      axi_rd(8'h20, 32'h0, RESP_SLVERR);
      axi_wr(8'h24, 32'h1, RESP_SLVERR);
      axi_wr(OFF_PAN, {16'h0, OWNP}, RESP_OKAY);
      axi_wr(OFF_SHORT, {16'h0, OWNS}, RESP_OKAY);
      axi_wr(OFF_LONG_LO, LNG[31:0], RESP_OKAY);
      axi_wr(OFF_LONG_HI, LNG[63:32], RESP_OKAY);
      // normal, ack-aware sniff, then both sniff bits together
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 32'h0 : 32'(i + 1);
         axi_wr(OFF_CTRL, c, RESP_OKAY);
         axi_rd(OFF_CTRL, c, RESP_OKAY);
         rx(mk(1, FT_DATA, 1, AM_SHORT, OWNP, OWNS, 64'h0, V), 3'b111);
         rx(mk(1, FT_CMD, 1, AM_SHORT, OWNP, 16'h0042, 64'h0, V), {c != 0, c != 0, 1'b0});
         rx(mk(1, FT_DATA, 1, AM_SHORT, OWNP, BCAST, 64'h0, V), 3'b110);
         rx(mk(1, FT_DATA, 1, AM_SHORT, BCAST, OWNS, 64'h0, V), 3'b110);
         rx(mk(1, FT_CMD, 1, AM_LONG, BCAST, 16'h0, LNG, V), 3'b111);
      end
      axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
      rx(mk(1, FT_DATA, 1, AM_SHORT, OWNP, OWNS, 64'h0, V), 3'b110);
      rx(mk(1, FT_DATA, 1, AM_SHORT, 16'h0777, OWNS, 64'h0, V), 3'b110);
      axi_wr(OFF_CTRL, 32'h6, RESP_OKAY);
      rx(mk(0, FT_DATA, 1, AM_SHORT, OWNP, OWNS, 64'h0, V), 3'b110);
      axi_wr(OFF_CTRL, 32'h2, RESP_OKAY);
      rx(mk(0, FT_DATA, 1, AM_SHORT, OWNP, OWNS, 64'h0, V), 3'b000);
      // interrupt: clear, mask in indication only, raise, clear again
      axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
      axi_wr(OFF_STATUS, 32'hf, RESP_OKAY);
      axi_wr(OFF_MASK, 32'h1, RESP_OKAY);
      chk("irq idle", 0, {31'h0, irq});
      rx(mk(1, FT_DATA, 1, AM_SHORT, OWNP, OWNS, 64'h0, V), 3'b111);
      @(posedge sys_clk);
      #1 chk("irq raised", 1, {31'h0, irq});
      axi_rd(OFF_STATUS, 32'h3, RESP_OKAY);
      axi_wr(OFF_STATUS, 32'h1, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq cleared", 0, {31'h0, irq});
      axi_rd(OFF_STATUS, 32'h2, RESP_OKAY);
      // transmit then receive
      axi_wr(OFF_CTRL, 32'h8, RESP_OKAY);
      tr(V, 1, 3'b100);
      tr(V ^ 10'h001, 1, 3'b000);
      tr(V ^ 10'h100, 1, 3'b000);
      axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
      tr(V, 0, 3'b000);
      axi_wr(OFF_CTRL, 32'ha, RESP_OKAY);
      tr(V, 1, 3'b110);
      axi_rd(OFF_LAST_RX, {22'h0, V}, RESP_OKAY);
      axi_rd(OFF_STATUS, 32'h7, RESP_OKAY);
      report_and_stop();
   end
endmodule
`default_nettype wire
